// ### lsoc_pkg.sv
// ****************************************************************
// Constants for the LED sink output control block
// ****************************************************************
package lsoc_pkg;
   localparam int NUM_CH = 48;
   localparam int NUM_GROUPS = 12;
   localparam int CH_PER_GROUP = NUM_CH / NUM_GROUPS;
   localparam int GS_W = 16;
   localparam int CODE_W = 9;
   localparam int GAIN_W = 3;
   localparam int THR_W = 2;
   localparam int DEPTH_W = 3;
   localparam int MIN_PWM_BITS = 9;
   // One grayscale clock between successive turn-on groups
   localparam int GROUP_DELAY_GRAYSCALE_CLOCK = 1;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_COLOR_RG = 12'h004;
   localparam logic [11:0] OFS_COLOR_B = 12'h008;
   localparam logic [11:0] OFS_LINE_RESTART = 12'h00c;
   localparam logic [11:0] OFS_OPEN_LO = 12'h010;
   localparam logic [11:0] OFS_OPEN_HI = 12'h014;
   localparam logic [11:0] OFS_BROKEN_LO = 12'h018;
   localparam logic [11:0] OFS_BROKEN_HI = 12'h01c;
   localparam logic [11:0] OFS_INT_STATUS = 12'h020;
   localparam logic [11:0] OFS_INT_MASK = 12'h024;
   localparam logic [11:0] OFS_LIVE = 12'h028;
   localparam logic [11:0] OFS_GS_BASE = 12'h100;
   localparam logic [11:0] OFS_GS_LAST = 12'h1bc;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_GAIN_LSB = 0;
   localparam int CTRL_THR_LSB = 4;
   localparam int CTRL_DEPTH_LSB = 8;
   localparam int RG_GREEN_LSB = 16;

   // Interrupt status bits
   localparam int IRQ_OPEN = 0;
   localparam int IRQ_OVER_TEMP = 1;
   localparam int IRQ_REF_SHORT = 2;
   localparam int IRQ_PERIOD = 3;
   localparam int IRQ_W = 4;

   // ****************************************************************
   // Reset values and full-scale code
   // ****************************************************************
   localparam logic [GAIN_W-1:0] GAIN_RESET = 3'h4;
   localparam logic [CODE_W-1:0] CODE_RESET = 9'h100;
   localparam logic [CODE_W-1:0] CODE_FULL = 9'h1ff;
   localparam logic [THR_W-1:0] THR_RESET = 2'h0;
   localparam logic [DEPTH_W-1:0] DEPTH_RESET = 3'h7;

   // Gain ratio per code in tenths of a percent
   localparam logic [9:0] GAIN_RATIO_PM [8] = '{10'h081, 10'h100, 10'h17b,
      10'h20c, 10'h287, 10'h2dd, 10'h395, 10'h3e8};
endpackage

// ### lsoc_top.sv
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module lsoc_top
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic grayscale_clock,
   input wire logic [lsoc_pkg::NUM_CH-1:0] below_threshold,
   input wire logic over_temp_shutdown,
   input wire logic ref_short_protect,
   input wire logic line_switching,
   output logic [lsoc_pkg::NUM_CH-1:0] sink_output,
   output logic [lsoc_pkg::NUM_CH-1:0] precharge_en,
   output logic [lsoc_pkg::GAIN_W-1:0] global_gain_code,
   output logic [7:0] gain_step_sel,
   output logic [9:0] gain_ratio_pm,
   output logic [lsoc_pkg::CODE_W-1:0] red_brightness_code,
   output logic [lsoc_pkg::CODE_W-1:0] green_brightness_code,
   output logic [lsoc_pkg::CODE_W-1:0] blue_brightness_code,
   output logic [lsoc_pkg::THR_W-1:0] open_detect_threshold_sel,
   output logic irq
);
   localparam int NCH = lsoc_pkg::NUM_CH;

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [NCH+3:0] meta_ff;
   logic [NCH+3:0] sync_ff;
   logic grayscale_clock_prev_ff;
   wire [NCH+3:0] raw_in = {line_switching, ref_short_protect,
      over_temp_shutdown, grayscale_clock, below_threshold};
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
         grayscale_clock_prev_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= raw_in;
         sync_ff <= meta_ff;
         grayscale_clock_prev_ff <= sync_ff[NCH];
      end
   end
   wire [NCH-1:0] below_s = sync_ff[NCH-1:0];
   wire grayscale_clock_rise = sync_ff[NCH] & ~grayscale_clock_prev_ff;
   wire hot_s = sync_ff[NCH+1];
   wire short_s = sync_ff[NCH+2];
   wire switch_s = sync_ff[NCH+3];

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [lsoc_pkg::GAIN_W-1:0] gain_ff;
   logic [lsoc_pkg::CODE_W-1:0] red_ff;
   logic [lsoc_pkg::CODE_W-1:0] green_ff;
   logic [lsoc_pkg::CODE_W-1:0] blue_ff;
   logic [lsoc_pkg::THR_W-1:0] thr_ff;
   logic [lsoc_pkg::DEPTH_W-1:0] depth_ff;
   logic suppress_ff;
   logic [lsoc_pkg::IRQ_W-1:0] int_stat_ff;
   logic [lsoc_pkg::IRQ_W-1:0] int_mask_ff;
   logic [lsoc_pkg::GS_W-1:0] gs_mem [NCH];
   logic [NCH-1:0] open_ff;
   logic [NCH-1:0] broken_ff;
   logic [NCH-1:0] sink_ff;
   logic [NCH-1:0] pre_ff;
   logic [lsoc_pkg::GS_W-1:0] cnt_ff;
   logic hot_prev_ff;
   logic short_prev_ff;

   // ****************************************************************
   // AHB-Lite slave
   // ****************************************************************
   logic wr_pend_ff;
   logic [11:0] wr_addr_ff;
   logic [31:0] rdata_ff;
   wire addr_phase = hsel & htrans[1] & hready;
   wire rd_take = addr_phase & ~hwrite;
   wire wr_take = addr_phase & hwrite;
   wire [11:0] a_ofs = {haddr[11:2], 2'b00};
   wire gs_hit_rd = (a_ofs >= lsoc_pkg::OFS_GS_BASE) &&
      (a_ofs <= lsoc_pkg::OFS_GS_LAST);
   wire [5:0] gs_idx_rd = 6'(a_ofs[7:2]);
   wire gs_hit_wr = (wr_addr_ff >= lsoc_pkg::OFS_GS_BASE) &&
      (wr_addr_ff <= lsoc_pkg::OFS_GS_LAST);
   wire [5:0] gs_idx_wr = 6'(wr_addr_ff[7:2]);
   wire wr_ctrl = wr_pend_ff && (wr_addr_ff == lsoc_pkg::OFS_CTRL);
   wire wr_rg = wr_pend_ff && (wr_addr_ff == lsoc_pkg::OFS_COLOR_RG);
   wire wr_b = wr_pend_ff && (wr_addr_ff == lsoc_pkg::OFS_COLOR_B);
   wire wr_lr = wr_pend_ff && (wr_addr_ff == lsoc_pkg::OFS_LINE_RESTART);
   wire wr_mask = wr_pend_ff && (wr_addr_ff == lsoc_pkg::OFS_INT_MASK);
   wire wr_gs = wr_pend_ff && gs_hit_wr;
   wire rd_stat = rd_take && (a_ofs == lsoc_pkg::OFS_INT_STATUS);

   // Read data mux, captured at the address phase
   logic [31:0] nxt_rdata;
   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      if (gs_hit_rd)
         nxt_rdata = {16'h0000, gs_mem[gs_idx_rd]};
      else
         case (a_ofs)
            lsoc_pkg::OFS_CTRL:
               nxt_rdata = {20'h00000, 1'b0, depth_ff, 2'b00, thr_ff,
                  1'b0, gain_ff};
            lsoc_pkg::OFS_COLOR_RG:
               nxt_rdata = {7'h00, green_ff, 7'h00, red_ff};
            lsoc_pkg::OFS_COLOR_B: nxt_rdata = {23'h000000, blue_ff};
            lsoc_pkg::OFS_LINE_RESTART: nxt_rdata = {31'h0, suppress_ff};
            lsoc_pkg::OFS_OPEN_LO: nxt_rdata = open_ff[31:0];
            lsoc_pkg::OFS_OPEN_HI: nxt_rdata = {16'h0000, open_ff[47:32]};
            lsoc_pkg::OFS_BROKEN_LO: nxt_rdata = broken_ff[31:0];
            lsoc_pkg::OFS_BROKEN_HI:
               nxt_rdata = {16'h0000, broken_ff[47:32]};
            lsoc_pkg::OFS_INT_STATUS: nxt_rdata = {28'h0, int_stat_ff};
            lsoc_pkg::OFS_INT_MASK: nxt_rdata = {28'h0, int_mask_ff};
            lsoc_pkg::OFS_LIVE:
               nxt_rdata = {29'h0, switch_s, short_s, hot_s};
            default: nxt_rdata = 32'h0000_0000;
         endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 12'h000;
         rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_ff <= wr_take;
         wr_addr_ff <= a_ofs;
         if (rd_take)
            rdata_ff <= nxt_rdata;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_ff;

   // ****************************************************************
   // Control registers
   // ****************************************************************
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         gain_ff <= lsoc_pkg::GAIN_RESET;
         red_ff <= lsoc_pkg::CODE_RESET;
         green_ff <= lsoc_pkg::CODE_RESET;
         blue_ff <= lsoc_pkg::CODE_RESET;
         thr_ff <= lsoc_pkg::THR_RESET;
         depth_ff <= lsoc_pkg::DEPTH_RESET;
         suppress_ff <= 1'b0;
         int_mask_ff <= '0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            gain_ff <= hwdata[lsoc_pkg::CTRL_GAIN_LSB +: lsoc_pkg::GAIN_W];
            thr_ff <= hwdata[lsoc_pkg::CTRL_THR_LSB +: lsoc_pkg::THR_W];
            depth_ff <= hwdata[lsoc_pkg::CTRL_DEPTH_LSB +:
               lsoc_pkg::DEPTH_W];
         end
         if (wr_rg)
         begin
            red_ff <= hwdata[lsoc_pkg::CODE_W-1:0];
            green_ff <= hwdata[lsoc_pkg::RG_GREEN_LSB +: lsoc_pkg::CODE_W];
         end
         if (wr_b)
            blue_ff <= hwdata[lsoc_pkg::CODE_W-1:0];
         if (wr_lr)
            suppress_ff <= hwdata[0];
         if (wr_mask)
            int_mask_ff <= hwdata[lsoc_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (wr_gs)
         gs_mem[gs_idx_wr] <= hwdata[lsoc_pkg::GS_W-1:0];
   end

   // Analog settings follow the registers with no period wait
   assign global_gain_code = gain_ff;
   assign gain_step_sel = 8'h01 << gain_ff;
   assign gain_ratio_pm = lsoc_pkg::GAIN_RATIO_PM[gain_ff];
   assign red_brightness_code = red_ff;
   assign green_brightness_code = green_ff;
   assign blue_brightness_code = blue_ff;
   assign open_detect_threshold_sel = thr_ff;

   // ****************************************************************
   // PWM period counter
   // ****************************************************************
   wire [4:0] pwm_bits = 5'(depth_ff) + 5'(lsoc_pkg::MIN_PWM_BITS);
   wire [16:0] period_len = 17'h00001 << pwm_bits;
   wire [lsoc_pkg::GS_W-1:0] gs_keep = 16'(period_len - 17'h00001);
   wire at_wrap = 17'(cnt_ff) >= (period_len - 17'h00001);
   wire period_start = grayscale_clock_rise & at_wrap;
   wire force_off = hot_s | short_s;
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         cnt_ff <= '0;
      else if (grayscale_clock_rise)
         cnt_ff <= at_wrap ? '0 : cnt_ff + 16'h0001;
   end

   // ****************************************************************
   // Per-channel output, open detect and suppression
   // ****************************************************************
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++)
      begin : g_ch
         localparam int GRP = ch / lsoc_pkg::CH_PER_GROUP;
         localparam logic [16:0] OFFS =
            17'(GRP * lsoc_pkg::GROUP_DELAY_GRAYSCALE_CLOCK);
         wire [16:0] cnt_x = {1'b0, cnt_ff};
         wire [16:0] duty = {1'b0, gs_mem[ch] & gs_keep};
         wire grp_live = cnt_x >= OFFS;
         wire in_duty = (cnt_x - OFFS) < duty;
         wire nxt_on = grp_live & in_duty & ~force_off & ~broken_ff[ch];
         wire nxt_open = sink_ff[ch] & below_s[ch];
         always_ff @(posedge core_clk)
         begin
            if (sys_rst)
            begin
               sink_ff[ch] <= 1'b0;
               open_ff[ch] <= 1'b0;
               broken_ff[ch] <= 1'b0;
               pre_ff[ch] <= 1'b0;
            end
            else
            begin
               sink_ff[ch] <= nxt_on;
               open_ff[ch] <= nxt_open;
               if (suppress_ff & nxt_open)
                  broken_ff[ch] <= 1'b1;
               pre_ff[ch] <= switch_s & ~nxt_on;
            end
         end
      end
   endgenerate
   assign sink_output = sink_ff;
   assign precharge_en = pre_ff;

   // ****************************************************************
   // Interrupt status, read clears, set wins
   // ****************************************************************
   logic [lsoc_pkg::IRQ_W-1:0] ev;
   always_comb
   begin
      ev = '0;
      ev[lsoc_pkg::IRQ_OPEN] = |(sink_ff & below_s & ~open_ff);
      ev[lsoc_pkg::IRQ_OVER_TEMP] = hot_s & ~hot_prev_ff;
      ev[lsoc_pkg::IRQ_REF_SHORT] = short_s & ~short_prev_ff;
      ev[lsoc_pkg::IRQ_PERIOD] = period_start;
   end
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         int_stat_ff <= '0;
         hot_prev_ff <= 1'b0;
         short_prev_ff <= 1'b0;
      end
      else
      begin
         int_stat_ff <= (rd_stat ? '0 : int_stat_ff) | ev;
         hot_prev_ff <= hot_s;
         short_prev_ff <= short_s;
      end
   end
   assign irq = |(int_stat_ff & int_mask_ff);
endmodule

// ### lsoc_props.sv
`timescale 1ns/10ps
// ****
// Port checker
// ****
module lsoc_props
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic over_temp_shutdown,
   input wire logic ref_short_protect,
   input wire logic line_switching,
   input wire logic [lsoc_pkg::NUM_CH-1:0] sink_output,
   input wire logic [lsoc_pkg::NUM_CH-1:0] precharge_en,
   input wire logic [lsoc_pkg::GAIN_W-1:0] global_gain_code,
   input wire logic [7:0] gain_step_sel,
   input wire logic [9:0] gain_ratio_pm,
   input wire logic [lsoc_pkg::CODE_W-1:0] red_brightness_code,
   input wire logic [lsoc_pkg::CODE_W-1:0] green_brightness_code
);
   wire logic wr_take;
   assign wr_take = hsel & htrans[1] & hready & hwrite;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_gain_onehot:
      assert property ($onehot(gain_step_sel) &&
         gain_step_sel[global_gain_code])
      else $error("gain step not one-hot of code");
   a_ratio_low:
      assert property (global_gain_code == 3'h0 |-> gain_ratio_pm == 10'h081)
      else $error("lowest gain ratio wrong");
   a_ratio_top:
      assert property (global_gain_code == 3'h7 |-> gain_ratio_pm == 10'h3e8)
      else $error("top gain ratio wrong");
   a_reset_vals:
      assert property ($fell(sys_rst) |-> global_gain_code == 3'h4 &&
         red_brightness_code == 9'h100 && green_brightness_code == 9'h100 &&
         sink_output == '0)
      else $error("reset values wrong");
   a_gain_write:
      assert property (wr_take && haddr[11:0] == 12'h000 |=> ##1
         global_gain_code == $past(hwdata[2:0]))
      else $error("gain write not applied");
   a_color_write:
      assert property (wr_take && haddr[11:0] == 12'h004 |=> ##1
         red_brightness_code == $past(hwdata[8:0]) &&
         green_brightness_code == $past(hwdata[24:16]))
      else $error("color write not applied");
   a_temp_off:
      assert property (over_temp_shutdown [*4] |-> sink_output == '0)
      else $error("output on during over temperature");
   a_short_off:
      assert property (ref_short_protect [*4] |-> sink_output == '0)
      else $error("output on during reference short");
   a_precharge_idle:
      assert property (!line_switching [*5] |-> precharge_en == '0)
      else $error("pre-charge on outside line switching");
endmodule

// ### lsoc_grayscale_clock_model.sv
`timescale 1ns/10ps
// ****
// Controller grayscale clock source
// ****
module lsoc_grayscale_clock_model
#(
   parameter int HALF = 4
)
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic run,
   output logic grayscale_clock
);
   int cnt = 0;
   // Stands low while stopped
   always @(posedge core_clk)
   begin
      if (sys_rst || !run)
      begin
         cnt <= 0;
         grayscale_clock <= 1'b0;
      end
      else if (cnt == HALF - 1)
      begin
         cnt <= 0;
         grayscale_clock <= !grayscale_clock;
      end
      else
         cnt <= cnt + 1;
   end
endmodule

// ### tb.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fails++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic over_temp_shutdown = 1'b0, ref_short_protect = 1'b0;
   logic line_switching = 1'b0;
   logic [47:0] below_threshold = 48'h0, sink_output, precharge_en;
   logic hready, hreadyout, hresp, irq, grayscale_clock;
   logic [2:0] global_gain_code;
   logic [7:0] gain_step_sel;
   logic [9:0] gain_ratio_pm;
   logic [8:0] red_brightness_code, green_brightness_code;
   logic [8:0] blue_brightness_code;
   logic [1:0] open_detect_threshold_sel;
   logic [9:0] ratio [8] = '{10'h081, 10'h100, 10'h17b, 10'h20c,
      10'h287, 10'h2dd, 10'h395, 10'h3e8};
   int fails = 0, checks = 0, g, n;
   assign hready = hreadyout;
   always #10 core_clk = ~core_clk;
   lsoc_grayscale_clock_model grayscale_clock_u (.core_clk, .sys_rst, .run, .grayscale_clock);
   lsoc_top dut_u (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
      .grayscale_clock, .below_threshold, .over_temp_shutdown,
      .ref_short_protect, .line_switching, .sink_output, .precharge_en,
      .global_gain_code, .gain_step_sel, .gain_ratio_pm,
      .red_brightness_code, .green_brightness_code, .blue_brightness_code,
      .open_detect_threshold_sel, .irq);
   // ****
   // Bus and wait tasks
   // ****
   task stop_test;
      if (fails == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   task rdy;
      int k;
      k = 0;
      do
      begin
         @(posedge core_clk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         fails++;
         stop_test();
      end
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, a};
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      r = hrdata;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d, q);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0, q);
      `CHK(nm, e, q)
      `CHK("resp", 1'b0, hresp)
   endtask
   task wait_rise(output int k);
      logic p;
      p = sink_output[0];
      for (k = 1; k <= 20000; k++)
      begin
         @(posedge core_clk);
         if (sink_output[0] === 1'b1 && p !== 1'b1)
            return;
         p = sink_output[0];
      end
      fails++;
      stop_test();
   endtask
   // ****
   // Main sequence
   // ****
   initial
   begin
      cyc(10);
      sys_rst <= 1'b0;
      rd(12'h000, 32'h0000_0704, "ctrl");
      rd(12'h004, 32'h0100_0100, "color_rg");
      rd(12'h008, 32'h0000_0100, "color_b");
      rd(12'h030, 32'h0, "unmapped");
      for (g = 0; g < 8; g++)
      begin
         wr(12'h000, 32'h700 + 32'h10 * (g % 4) + g);
         cyc(1);
         `CHK("gain", g[2:0], global_gain_code)
         `CHK("ratio", ratio[g], gain_ratio_pm)
         `CHK("thr", g[1:0], open_detect_threshold_sel)
      end
      wr(12'h004, 32'h0000_01ff);
      wr(12'h008, 32'h0000_0155);
      cyc(1);
      `CHK("red", 9'h1ff, red_brightness_code)
      `CHK("green", 9'h000, green_brightness_code)
      `CHK("blue", 9'h155, blue_brightness_code)
      for (g = 0; g < 48; g++)
         wr(12'h100 + 12'(4 * g), g == 47 ? 32'h0 : 32'h0000_00c8);
      run <= 1'b1;
      for (g = 0; g < 2; g++)
      begin
         wr(12'h000, 32'h4 + 32'h100 * g);
         wait_rise(n);
         wait_rise(n);
         `CHK("period", 4096 << g, n)
      end
      wait_rise(n);
      cyc(4);
      `CHK("grp0", 2'b01, sink_output[4:3])
      cyc(8);
      `CHK("grp1", 2'b01, sink_output[8:7])
      cyc(160);
      below_threshold <= 48'hc000_0000_0000;
      cyc(8);
      rd(12'h014, 32'h0000_4000, "open_hi");
      rd(12'h020, 32'h0000_0009, "status");
      for (g = 0; g < 2; g++)
      begin
         wr(12'h024, 32'h2 << g);
         cyc(1);
         `CHK("irq_idle", 1'b0, irq)
         if (g == 0)
            over_temp_shutdown <= 1'b1;
         else
            ref_short_protect <= 1'b1;
         cyc(6);
         `CHK("forced_off", 48'h0, sink_output)
         `CHK("irq_set", 1'b1, irq)
         bus(1'b0, 12'h020, 32'h0, q);
         `CHK("cause", 32'h2 << g, q & (32'h2 << g))
         cyc(1);
         `CHK("irq_clr", 1'b0, irq)
         over_temp_shutdown <= 1'b0;
         ref_short_protect <= 1'b0;
         cyc(6);
         `CHK("resumed", 48'h7fff_ffff_ffff, sink_output)
      end
      line_switching <= 1'b1;
      cyc(6);
      `CHK("pre_on", 48'h8000_0000_0000, precharge_en)
      line_switching <= 1'b0;
      cyc(6);
      `CHK("pre_off", 48'h0, precharge_en)
      wr(12'h00c, 32'h1);
      cyc(8);
      `CHK("broken", 2'b01, sink_output[46:45])
      rd(12'h01c, 32'h0000_4000, "broken_hi");
      wr(12'h00c, 32'h0);
      below_threshold <= 48'h0;
      cyc(8);
      `CHK("kept_off", 1'b0, sink_output[46])
      sys_rst <= 1'b1;
      cyc(3);
      sys_rst <= 1'b0;
      rd(12'h01c, 32'h0, "broken_clr");
      rd(12'h000, 32'h0000_0704, "ctrl_again");
      stop_test();
   end
endmodule
bind lsoc_top lsoc_props chk_u (.core_clk, .sys_rst, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .over_temp_shutdown,
   .ref_short_protect, .line_switching, .sink_output, .precharge_en,
   .global_gain_code, .gain_step_sel, .gain_ratio_pm,
   .red_brightness_code, .green_brightness_code);
